/* rtl/gss_top.sv */
/*
 * Ground start signaling, one state machine per T1 channel.
 * Assumes receive A/B bits already extracted, synchronous to i_ref_clk.
 */
`timescale 1ns/10ps
module gss_top
(
    // clock and reset
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_arst_n,
    // signaling from terminal, per channel
    input  wire logic [gss_pkg::NUM_CH-1:0] i_rx_a,
    input  wire logic [gss_pkg::NUM_CH-1:0] i_rx_b,
    // system commands, per channel
    input  wire logic [gss_pkg::NUM_CH-1:0] i_ring_req,
    input  wire logic [gss_pkg::NUM_CH-1:0] i_far_release,
    // configuration
    input  wire logic [gss_pkg::NUM_CH-1:0] i_sup_line_en,
    input  wire logic [gss_pkg::NUM_CH-1:0] i_batt_rev_en,
    input  wire logic [gss_pkg::NUM_CH-1:0] i_hook_flash_en,
    input  wire logic [7:0]                 i_tip_open_steps,
    // voice
    input  wire logic [gss_pkg::PCM_W-1:0]  i_tx_pcm,
    input  wire logic [gss_pkg::PCM_W-1:0]  i_rx_pcm,
    output logic      [gss_pkg::PCM_W-1:0]  o_tx_pcm,
    output logic      [gss_pkg::PCM_W-1:0]  o_rx_pcm,
    // signaling to terminal, per channel
    output logic      [gss_pkg::NUM_CH-1:0] o_tx_a,
    output logic      [gss_pkg::NUM_CH-1:0] o_tx_b,
    // status, per channel
    output logic      [gss_pkg::NUM_CH-1:0] o_offhook,
    output logic      [gss_pkg::NUM_CH-1:0] o_seize,
    output logic      [gss_pkg::NUM_CH-1:0] o_answer,
    output logic      [gss_pkg::NUM_CH-1:0] o_onhook
);
    localparam int unsigned N = gss_pkg::NUM_CH;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // shared 10 ms step and voice pad
    // ------------------------------------------------------------
    logic step;

    gss_tick u_tick
    (
        .i_clk   (i_ref_clk),
        .i_rst_n (rst_n_ff),
        .o_step  (step)
    );

    gss_pad u_pad
    (
        .i_clk    (i_ref_clk),
        .i_rst_n  (rst_n_ff),
        .i_tx_pcm (i_tx_pcm),
        .i_rx_pcm (i_rx_pcm),
        .o_tx_pcm (o_tx_pcm),
        .o_rx_pcm (o_rx_pcm)
    );

    // ------------------------------------------------------------
    // ring cadence, shared by all ringing channels
    // ------------------------------------------------------------
    logic [7:0] cad_cnt_ff;
    logic       cad_on_ff;

    always_ff @(posedge i_ref_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            cad_cnt_ff <= '0;
            cad_on_ff  <= 1'b1;
        end
        else if (step)
        begin
            if (cad_cnt_ff == 8'(gss_pkg::RING_HALF_ST - 1))
            begin
                cad_cnt_ff <= '0;
                cad_on_ff  <= ~cad_on_ff;
            end
            else
            begin
                cad_cnt_ff <= cad_cnt_ff + 8'h01;
            end
        end
    end

    // the tip-open time is sampled when a channel enters tip-open
    function automatic logic [7:0] gss_open_len(input logic [7:0] steps);
        gss_open_len = (steps == 8'h00) ? gss_pkg::TIP_OPEN_DEF : steps;
    endfunction

    // ------------------------------------------------------------
    // per-channel state machines
    // ------------------------------------------------------------
    gss_pkg::gss_state_t state_ff [N];
    logic [7:0]          tmr_ff   [N];
    logic [N-1:0]        rx_a_ff;
    logic [N-1:0]        rx_b_ff;
    logic [N-1:0]        orig_ff;
    logic [N-1:0]        rise_a;
    logic [N-1:0]        fall_a;
    logic [N-1:0]        fall_b;

    // idle, ring and call act on transitions of received bits; seized and tip-open act on levels
    assign rise_a = i_rx_a & ~rx_a_ff;
    assign fall_a = ~i_rx_a & rx_a_ff;
    assign fall_b = ~i_rx_b & rx_b_ff;

    always_ff @(posedge i_ref_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            rx_a_ff <= {N{gss_pkg::LOOP_OPEN}};
            rx_b_ff <= {N{gss_pkg::RGND_OFF}};
        end
        else
        begin
            rx_a_ff <= i_rx_a;
            rx_b_ff <= i_rx_b;
        end
    end

    for (genvar c = 0; c < N; c++)
    begin : g_ch
        // far release only acts when the option covers this call direction
        logic sup_ok;
        assign sup_ok = i_sup_line_en[c] &&
                        (orig_ff[c] ? i_batt_rev_en[c] : i_hook_flash_en[c]);

        always_ff @(posedge i_ref_clk or negedge rst_n_ff)
        begin
            if (!rst_n_ff)
            begin
                state_ff[c] <= gss_pkg::ST_IDLE;
                tmr_ff[c]   <= '0;
                orig_ff[c]  <= 1'b0;
            end
            else
            begin
                case (state_ff[c])
                    gss_pkg::ST_IDLE:
                    begin
                        // ring request checked first: system never backs down
                        if (i_ring_req[c])
                        begin
                            state_ff[c] <= gss_pkg::ST_RING;
                            orig_ff[c]  <= 1'b0;
                        end
                        else if (fall_b[c])
                        begin
                            state_ff[c] <= gss_pkg::ST_SEIZED;
                            orig_ff[c]  <= 1'b1;
                        end
                    end
                    gss_pkg::ST_RING:
                    begin
                        if (rise_a[c] && i_rx_b[c] == gss_pkg::RGND_OFF)
                            state_ff[c] <= gss_pkg::ST_CALL;
                        else if (!i_ring_req[c])
                            state_ff[c] <= gss_pkg::ST_IDLE;
                    end
                    gss_pkg::ST_SEIZED:
                    begin
                        // terminal drops ring ground and closes loop
                        if (i_rx_a[c] == gss_pkg::LOOP_CLOSED &&
                            i_rx_b[c] == gss_pkg::RGND_OFF)
                            state_ff[c] <= gss_pkg::ST_CALL;
                    end
                    gss_pkg::ST_CALL:
                    begin
                        if (fall_a[c])
                            state_ff[c] <= gss_pkg::ST_IDLE;
                        else if (i_far_release[c] && sup_ok)
                        begin
                            state_ff[c] <= gss_pkg::ST_TIPOPEN;
                            tmr_ff[c]   <= gss_open_len(i_tip_open_steps);
                        end
                    end
                    gss_pkg::ST_TIPOPEN:
                    begin
                        if (i_rx_a[c] == gss_pkg::LOOP_OPEN)
                            state_ff[c] <= gss_pkg::ST_IDLE;
                        else if (step && tmr_ff[c] == 8'h01)
                            state_ff[c] <= gss_pkg::ST_CALL;
                        else if (step)
                            tmr_ff[c] <= tmr_ff[c] - 8'h01;
                    end
                    default:
                        state_ff[c] <= gss_pkg::ST_IDLE;
                endcase
            end
        end

        // transmit bits decoded from registered state; status also from receive edges and ring request
        always_ff @(posedge i_ref_clk or negedge rst_n_ff)
        begin
            if (!rst_n_ff)
            begin
                o_tx_a[c] <= gss_pkg::TIP_OPEN;
                o_tx_b[c] <= gss_pkg::RING_OFF;
            end
            else
            begin
                case (state_ff[c])
                    gss_pkg::ST_RING:
                    begin
                        o_tx_a[c] <= gss_pkg::TIP_GROUNDED;
                        o_tx_b[c] <= cad_on_ff ? gss_pkg::RING_ON : gss_pkg::RING_OFF;
                    end
                    gss_pkg::ST_SEIZED, gss_pkg::ST_CALL:
                    begin
                        // without the option tip stays grounded until loop opens
                        o_tx_a[c] <= gss_pkg::TIP_GROUNDED;
                        o_tx_b[c] <= gss_pkg::RING_OFF;
                    end
                    default:
                    begin
                        o_tx_a[c] <= gss_pkg::TIP_OPEN;
                        o_tx_b[c] <= gss_pkg::RING_OFF;
                    end
                endcase
            end
        end

        always_ff @(posedge i_ref_clk or negedge rst_n_ff)
        begin
            if (!rst_n_ff)
            begin
                o_offhook[c] <= 1'b0;
                o_seize[c]   <= 1'b0;
                o_answer[c]  <= 1'b0;
                o_onhook[c]  <= 1'b0;
            end
            else
            begin
                o_offhook[c] <= (state_ff[c] == gss_pkg::ST_CALL);
                o_seize[c]   <= (state_ff[c] == gss_pkg::ST_IDLE) && !i_ring_req[c] && fall_b[c];
                o_answer[c]  <= (state_ff[c] == gss_pkg::ST_RING) && rise_a[c] && i_rx_b[c];
                o_onhook[c]  <= (state_ff[c] == gss_pkg::ST_CALL) && fall_a[c];
            end
        end

        // --------------------------------------------------------
        // checks
        // --------------------------------------------------------
        a_idle_bits: assert property (@(posedge i_ref_clk) disable iff (!rst_n_ff)
            $past(state_ff[c]) == gss_pkg::ST_IDLE |-> o_tx_a[c] && o_tx_b[c])
            else $error("idle channel not sending A=1 B=1");
        a_ring_tip: assert property (@(posedge i_ref_clk) disable iff (!rst_n_ff)
            state_ff[c] == gss_pkg::ST_RING ##1 state_ff[c] == gss_pkg::ST_RING
            |-> !o_tx_a[c])
            else $error("tip not grounded while ringing");
        a_answer_move: assert property (@(posedge i_ref_clk) disable iff (!rst_n_ff)
            state_ff[c] == gss_pkg::ST_RING && rise_a[c] && i_rx_b[c]
            |=> state_ff[c] == gss_pkg::ST_CALL ##1 o_tx_b[c])
            else $error("answer not taken or ring not stopped");
        a_seize_ack: assert property (@(posedge i_ref_clk) disable iff (!rst_n_ff)
            state_ff[c] == gss_pkg::ST_IDLE && fall_b[c] && !i_ring_req[c]
            |-> ##2 !o_tx_a[c] && o_tx_b[c])
            else $error("seizure not acknowledged");
        a_glare_wins: assert property (@(posedge i_ref_clk) disable iff (!rst_n_ff)
            state_ff[c] == gss_pkg::ST_IDLE && i_ring_req[c]
            |=> state_ff[c] == gss_pkg::ST_RING)
            else $error("terminating call backed down");
        a_no_sup_hold: assert property (@(posedge i_ref_clk) disable iff (!rst_n_ff)
            state_ff[c] == gss_pkg::ST_CALL && !i_sup_line_en[c] && !fall_a[c]
            |=> state_ff[c] == gss_pkg::ST_CALL)
            else $error("call left without loop open");
        a_onhook_idle: assert property (@(posedge i_ref_clk) disable iff (!rst_n_ff)
            state_ff[c] == gss_pkg::ST_CALL && fall_a[c]
            |-> ##2 o_tx_a[c])
            else $error("tip not opened after on-hook");
        a_tip_open: assert property (@(posedge i_ref_clk) disable iff (!rst_n_ff)
            state_ff[c] == gss_pkg::ST_CALL && !fall_a[c] && i_far_release[c] && sup_ok
            |-> ##2 o_tx_a[c])
            else $error("far release did not open tip");
        a_open_len: assert property (@(posedge i_ref_clk) disable iff (!rst_n_ff)
            state_ff[c] == gss_pkg::ST_CALL && !fall_a[c] && i_far_release[c] && sup_ok
            |=> tmr_ff[c] == ($past(i_tip_open_steps) != 8'h00 ? $past(i_tip_open_steps)
                                                                : gss_pkg::TIP_OPEN_DEF))
            else $error("tip-open time not loaded");
        c_glare: cover property (@(posedge i_ref_clk)
            state_ff[c] == gss_pkg::ST_IDLE && i_ring_req[c] && fall_b[c]);
        c_ring_answer: cover property (@(posedge i_ref_clk)
            state_ff[c] == gss_pkg::ST_RING ##1 state_ff[c] == gss_pkg::ST_CALL);
        c_seize_call: cover property (@(posedge i_ref_clk)
            state_ff[c] == gss_pkg::ST_SEIZED ##1 state_ff[c] == gss_pkg::ST_CALL);
        c_far_disc: cover property (@(posedge i_ref_clk)
            state_ff[c] == gss_pkg::ST_TIPOPEN ##1 state_ff[c] == gss_pkg::ST_IDLE);
    end
endmodule

/* include/gss_pkg.sv */
/*
 * Constants for the ground start channel signaling block.
 * Assumes a 40 MHz reference clock; no imports are used by clients.
 */
package gss_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int unsigned NUM_CH       = 24;
    localparam int unsigned PCM_W        = 8;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned STEP_MS      = 10;
    localparam int unsigned STEP_CYC     = CLK_HZ / 1000 * STEP_MS;
    localparam int unsigned TIP_OPEN_MS  = 750;
    localparam logic [7:0]  TIP_OPEN_DEF = 8'(TIP_OPEN_MS / STEP_MS);
    localparam int unsigned RING_HALF_MS = 1000;
    localparam int unsigned RING_HALF_ST = RING_HALF_MS / STEP_MS;
    localparam int unsigned STEP_W       = $clog2(STEP_CYC);
    // ------------------------------------------------------------
    // signaling bit encodings
    // ------------------------------------------------------------
    localparam logic TIP_GROUNDED = 1'b0;
    localparam logic TIP_OPEN     = 1'b1;
    localparam logic RING_ON      = 1'b0;
    localparam logic RING_OFF     = 1'b1;
    localparam logic LOOP_OPEN    = 1'b0;
    localparam logic LOOP_CLOSED  = 1'b1;
    localparam logic RGND_ON      = 1'b0;
    localparam logic RGND_OFF     = 1'b1;
    // ------------------------------------------------------------
    // channel states, gray along idle->seize->call
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_RING    = 3'h1,
        ST_CALL    = 3'h3,
        ST_SEIZED  = 3'h2,
        ST_TIPOPEN = 3'h6
    } gss_state_t;
endpackage

/* rtl/gss_tick.sv */
/*
 * Free-running 10 ms step generator.
 * Assumes active-low reset from the top, asserted asynchronously and released synchronously.
 */
`timescale 1ns/10ps
module gss_tick
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // step pulse
    output logic      o_step
);
    localparam int unsigned W = gss_pkg::STEP_W;

    logic [W-1:0] cnt_ff;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_ff <= '0;
            o_step <= 1'b0;
        end
        else if (cnt_ff == W'(gss_pkg::STEP_CYC - 1))
        begin
            cnt_ff <= '0;
            o_step <= 1'b1;
        end
        else
        begin
            cnt_ff <= cnt_ff + W'(1);
            o_step <= 1'b0;
        end
    end
endmodule

/* rtl/gss_pad.sv */
/*
 * Fixed 0 dB voice pad, both directions, registered.
 * Assumes one PCM byte per channel slot arrives with its strobe.
 */
`timescale 1ns/10ps
module gss_pad
(
    // clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_n,
    // voice in
    input  wire logic [gss_pkg::PCM_W-1:0] i_tx_pcm,
    input  wire logic [gss_pkg::PCM_W-1:0] i_rx_pcm,
    // voice out
    output logic      [gss_pkg::PCM_W-1:0] o_tx_pcm,
    output logic      [gss_pkg::PCM_W-1:0] o_rx_pcm
);
    // 0 dB insertion loss: samples pass unscaled for every call type
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_tx_pcm <= '0;
            o_rx_pcm <= '0;
        end
        else
        begin
            o_tx_pcm <= i_tx_pcm;
            o_rx_pcm <= i_rx_pcm;
        end
    end
endmodule

/* dv/gss_term_model.sv */
/*
 * Terminal equipment model for every ground start channel.
 * Assumes tx bits from the block and per-channel off-hook wishes from the bench.
 */
`timescale 1ns/10ps
module gss_term_model
(
    // clock
    input  wire logic                       i_clk,
    // signaling from the block
    input  wire logic [gss_pkg::NUM_CH-1:0] i_tx_a,
    input  wire logic [gss_pkg::NUM_CH-1:0] i_tx_b,
    // wishes from the bench
    input  wire logic [gss_pkg::NUM_CH-1:0] i_want,
    input  wire logic [3:0]                 i_lag,
    // signaling to the block
    output logic      [gss_pkg::NUM_CH-1:0] o_rx_a,
    output logic      [gss_pkg::NUM_CH-1:0] o_rx_b
);
    int st  [gss_pkg::NUM_CH];
    int cnt [gss_pkg::NUM_CH];

    initial
    begin
        o_rx_a = '0;
        o_rx_b = '1;
        foreach (st[i])
        begin
            st[i]  = 0;
            cnt[i] = 15;
        end
    end

    // one reaction per channel, no sooner than the lag allows
    task automatic go(input int i, input logic a, input logic b, input int s);
        o_rx_a[i] <= #1 a;
        o_rx_b[i] <= #1 b;
        st[i] = s;
        cnt[i] = 0;
    endtask

    always @(posedge i_clk)
    begin
        for (int i = 0; i < gss_pkg::NUM_CH; i++)
        begin
            if (cnt[i] < 15)
                cnt[i]++;
            if (cnt[i] >= int'(i_lag))
                case (st[i])
                    0: if (i_want[i] && i_tx_b[i] === 1'b0) go(i, 1'b1, 1'b1, 2);
                       else if (i_want[i] && i_tx_a[i] === 1'b1) go(i, 1'b0, 1'b0, 1);
                    1: if (i_tx_a[i] === 1'b0) go(i, 1'b1, 1'b1, 2);
                    2: if (!i_want[i] || i_tx_a[i] === 1'b1) go(i, 1'b0, 1'b1, 3);
                    // stay on-hook until the bench drops its wish, so no reseize
                    default: if (!i_want[i]) st[i] = 0;
                endcase
        end
    end
endmodule

/* dv/tb.sv */
/*
 * Self-checking bench for the ground start block with a terminal model.
 * Assumes the block and model files are compiled before this one.
 */
`timescale 1ns/10ps
module tb;
    logic                       i_ref_clk = 1'b0;
    logic                       i_arst_n  = 1'b0;
    logic [gss_pkg::NUM_CH-1:0] rx_a, rx_b, tx_a, tx_b, offhook, seize, answer, onhook;
    logic [gss_pkg::NUM_CH-1:0] ring_req = '0, far_rel = '0, want = '0;
    logic [gss_pkg::NUM_CH-1:0] sup_en = '0, batt_en = '0, hook_en = '0;
    logic [gss_pkg::NUM_CH-1:0] ea = '1, eb = '1, saw_seize = '0, saw_ans = '0, saw_on = '0;
    logic [gss_pkg::PCM_W-1:0]  tpcm = '0, rpcm = '0, tpcm_o, rpcm_o;
    logic [3:0]                 lag = 4'h0;
    logic [7:0]                 tip_steps = 8'h01;
    logic [gss_pkg::PCM_W-1:0]  pcm_q [$];
    int                         seed = 32'hc5293b56;
    int                         bad_count = 0;
    int                         checked = 0;
    int                         ch;
    logic                       opened;

    always #12.5 i_ref_clk = ~i_ref_clk;

    gss_top gss_top_inst (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_rx_a(rx_a),
        .i_rx_b(rx_b), .i_ring_req(ring_req), .i_far_release(far_rel), .i_sup_line_en(sup_en),
        .i_batt_rev_en(batt_en), .i_hook_flash_en(hook_en), .i_tip_open_steps(tip_steps),
        .i_tx_pcm(tpcm), .i_rx_pcm(rpcm), .o_tx_pcm(tpcm_o), .o_rx_pcm(rpcm_o), .o_tx_a(tx_a),
        .o_tx_b(tx_b), .o_offhook(offhook), .o_seize(seize), .o_answer(answer),
        .o_onhook(onhook));

    gss_term_model gss_term_model_inst (.i_clk(i_ref_clk), .i_tx_a(tx_a), .i_tx_b(tx_b),
        .i_want(want), .i_lag(lag), .o_rx_a(rx_a), .o_rx_b(rx_b));

    // one-cycle status pulses are caught here so a later look cannot miss them
    always @(posedge i_ref_clk)
    begin
        saw_seize = saw_seize | seize;
        saw_ans   = saw_ans | answer;
        saw_on    = saw_on | onhook;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_tx();
        cmp("tx_a", ea, tx_a);
        cmp("tx_b", eb, tx_b);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // terminal-originated call up to steady state
    task automatic orig(input int c);
        saw_seize = '0;
        lag = 4'($random(seed) & 3);
        want[c] = 1'b1;
        tick(24);
        ea[c] = 1'b0;
        check_tx();
        cmp("seize", 24'h1 << c, saw_seize);
        cmp("offhook", 24'h1 << c, offhook);
    endtask

    // system-terminated call: ring, answer, ringing stops
    task automatic term(input int c);
        saw_ans = '0;
        ring_req[c] = 1'b1;
        tick(4);
        ea[c] = 1'b0;
        eb[c] = 1'b0;
        check_tx();
        want[c] = 1'b1;
        tick(24);
        ring_req[c] = 1'b0;
        eb[c] = 1'b1;
        check_tx();
        cmp("answer", 24'h1 << c, saw_ans);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        fork
            begin
                tick(20000);
                bad_count++;
                complete_run();
            end
        join_none
        tick(20);
        i_arst_n = 1'b1;
        tick(3);
        check_tx();
        cmp("offhook", 24'h0, offhook);
        // plain ringing call ended by the terminal going on-hook
        term(0);
        saw_on = '0;
        want[0] = 1'b0;
        tick(24);
        ea[0] = 1'b1;
        check_tx();
        cmp("onhook", 24'h1, saw_on);
        // far release across every batt_en/hook_en mix with sup_en on; last pass has the option off
        for (int k = 0; k < 9; k++)
        begin
            ch = 4 + k;
            // zero asks for the default tip-open time
            tip_steps = (k == 2) ? 8'h00 : 8'($random(seed));
            sup_en[ch] = (k < 8);
            {batt_en[ch], hook_en[ch]} = (k < 8) ? k[1:0] : 2'h3;
            // each call direction on its own channels
            if (k < 4 || k == 8)
                orig(ch);
            else
                term(ch);
            opened = sup_en[ch] && ((k < 4 || k == 8) ? batt_en[ch] : hook_en[ch]);
            far_rel[ch] = 1'b1;
            tick(1);
            far_rel[ch] = 1'b0;
            tick(24);
            ea[ch] = opened;
            check_tx();
            want[ch] = 1'b0;
            tick(24);
            ea[ch] = 1'b1;
            check_tx();
        end
        // both sides seize at once: the ringing call must win
        saw_seize = '0;
        saw_ans = '0;
        // ring request and seizure reach the block on the same edge
        want[20] = 1'b1;
        tick(1);
        ring_req[20] = 1'b1;
        tick(30);
        ring_req[20] = 1'b0;
        ea[20] = 1'b0;
        check_tx();
        cmp("glare_ans", 24'h1 << 20, saw_ans);
        cmp("glare_seize", 24'h0, saw_seize);
        want[20] = 1'b0;
        tick(24);
        ea[20] = 1'b1;
        check_tx();
        // voice passes unchanged both ways
        for (int k = 0; k < 16; k++)
        begin
            tpcm = 8'($random(seed));
            rpcm = 8'($random(seed));
            pcm_q.push_back(tpcm);
            pcm_q.push_back(rpcm);
            tick(1);
            cmp("tx_pcm", 24'(pcm_q.pop_front()), 24'(tpcm_o));
            cmp("rx_pcm", 24'(pcm_q.pop_front()), 24'(rpcm_o));
        end
        complete_run();
    end
endmodule
